// *** tpb_timer_pwm.sv ***
// Two 8-bit timers with pulse-width outputs and a tone output on the second timer.
// Assumes software drives the mode bits and write strobes on ref_clk.
//
// What this block does
// - Tone toggles each overflow: half interval rate
// - Tone enable drives shared pin, disables I/O
// - Run clear stops count, tone, pulse output
// - Rate field three bits, all eight codes
// - Source: CPU clear, oscillator set, ignored external
// - Auto-load bit set enables reload
// - Pulse mode: modulo-256 count against reference
// - Output high below reference, else low
// - Wrap to zero starts new high period
// - Duty equals reference over 256
// - Reference write-only; software avoids read-modify-write
// - Count write changes duty immediately
// - Pulse enable drives pin, disables I/O
// - Overflow raises request flag in pulse mode
// - Second timer: three function enables; tone overrides pulse on the pin, pulse overrides auto-load
// - Overflow with auto-load copies reload value
// - Pulse mode overrides auto-load: wraps to zero at 256 boundary
`timescale 1ns/1ps
module tpb_timer_pwm
  import tpb_pkg::*;
#(
  parameter int CPU_DIV = 4
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Timer A mode bits
  input wire logic timerARun,
  input wire logic [2:0] timerARateField,
  input wire logic timerAOscSourceSel,
  input wire logic timerAAutoload,
  input wire logic timerAExtMode,
  input wire logic timerAPulseOutEnable,
  input wire logic timerAIrqEnable,
  // Timer A data writes and flag clear
  input wire logic timerACountWr,
  input wire logic timerARefWr,
  input wire logic [7:0] timerAWrData,
  input wire logic timerAIrqClr,
  // Timer B mode bits
  input wire logic timerBRun,
  input wire logic [2:0] timerBRateField,
  input wire logic timerBOscSourceSel,
  input wire logic timerBAutoload,
  input wire logic timerBExtMode,
  input wire logic timerBPulseOutEnable,
  input wire logic timerBIrqEnable,
  input wire logic toneOutputEnable,
  // Timer B data writes and flag clear
  input wire logic timerBCountWr,
  input wire logic timerBRefWr,
  input wire logic [7:0] timerBWrData,
  input wire logic timerBIrqClr,
  // External event pins
  input wire logic timerAEventPin,
  input wire logic timerBEventPin,
  // Status
  output logic [7:0] timerACount,
  output logic [7:0] timerBCount,
  output logic timerAIrqFlag,
  output logic timerBIrqFlag,
  output logic timerAIrqReq,
  output logic timerBIrqReq,
  // Pin A: pulse output
  output logic timerAPinOut,
  output logic timerAPinOe,
  // Pin B: shared tone and pulse output
  output logic toneOutPinSignal,
  output logic timerBPinOe
);

  logic [7:0] cpuCnt;
  logic cpuTick;
  logic run [TPB_NUM_TIMERS];
  logic [2:0] rate [TPB_NUM_TIMERS];
  logic oscSel [TPB_NUM_TIMERS];
  logic autoload [TPB_NUM_TIMERS];
  logic extMode [TPB_NUM_TIMERS];
  logic pulseEn [TPB_NUM_TIMERS];
  logic irqEn [TPB_NUM_TIMERS];
  logic countWr [TPB_NUM_TIMERS];
  logic refWr [TPB_NUM_TIMERS];
  logic [7:0] wrData [TPB_NUM_TIMERS];
  logic irqClr [TPB_NUM_TIMERS];
  logic eventPin [TPB_NUM_TIMERS];
  logic [7:0] count [TPB_NUM_TIMERS];
  logic [7:0] refVal [TPB_NUM_TIMERS];
  logic irqFlag [TPB_NUM_TIMERS];
  logic irqReq [TPB_NUM_TIMERS];
  logic pulseOut [TPB_NUM_TIMERS];
  logic [7:0] next_count [TPB_NUM_TIMERS];
  logic overflow [TPB_NUM_TIMERS];
  logic tick [TPB_NUM_TIMERS];
  logic tone;
  logic next_tone;

  // ==========================================================================
  // Port gathering
  assign run[TPB_TIMER_A] = timerARun;
  assign rate[TPB_TIMER_A] = timerARateField;
  assign oscSel[TPB_TIMER_A] = timerAOscSourceSel;
  assign autoload[TPB_TIMER_A] = timerAAutoload;
  assign extMode[TPB_TIMER_A] = timerAExtMode;
  assign pulseEn[TPB_TIMER_A] = timerAPulseOutEnable;
  assign irqEn[TPB_TIMER_A] = timerAIrqEnable;
  assign countWr[TPB_TIMER_A] = timerACountWr;
  assign refWr[TPB_TIMER_A] = timerARefWr;
  assign wrData[TPB_TIMER_A] = timerAWrData;
  assign irqClr[TPB_TIMER_A] = timerAIrqClr;
  assign eventPin[TPB_TIMER_A] = timerAEventPin;

  assign run[TPB_TIMER_B] = timerBRun;
  assign rate[TPB_TIMER_B] = timerBRateField;
  assign oscSel[TPB_TIMER_B] = timerBOscSourceSel;
  assign autoload[TPB_TIMER_B] = timerBAutoload;
  assign extMode[TPB_TIMER_B] = timerBExtMode;
  assign pulseEn[TPB_TIMER_B] = timerBPulseOutEnable;
  assign irqEn[TPB_TIMER_B] = timerBIrqEnable;
  assign countWr[TPB_TIMER_B] = timerBCountWr;
  assign refWr[TPB_TIMER_B] = timerBRefWr;
  assign wrData[TPB_TIMER_B] = timerBWrData;
  assign irqClr[TPB_TIMER_B] = timerBIrqClr;
  assign eventPin[TPB_TIMER_B] = timerBEventPin;

  assign timerACount = count[TPB_TIMER_A];
  assign timerBCount = count[TPB_TIMER_B];
  assign timerAIrqFlag = irqFlag[TPB_TIMER_A];
  assign timerBIrqFlag = irqFlag[TPB_TIMER_B];
  assign timerAIrqReq = irqReq[TPB_TIMER_A];
  assign timerBIrqReq = irqReq[TPB_TIMER_B];

  // ==========================================================================
  // CPU clock tick from reference clock
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cpuCnt <= 8'h00;
      cpuTick <= 1'b0;
    end
    else if (cpuCnt == 8'(CPU_DIV - 1))
    begin
      cpuCnt <= 8'h00;
      cpuTick <= 1'b1;
    end
    else
    begin
      cpuCnt <= cpuCnt + 8'h01;
      cpuTick <= 1'b0;
    end
  end

  // ==========================================================================
  // Per-timer core
  for (genvar g = 0; g < TPB_NUM_TIMERS; g++)
  begin : gTimer
    tpb_tick_if tk ();

    assign tk.run = run[g];
    assign tk.rate = rate[g];
    assign tk.oscSel = oscSel[g];
    assign tk.extMode = extMode[g];
    assign tk.cpuTick = cpuTick;
    assign tick[g] = tk.tick;

    tpb_rate_div uDiv (
      .ref_clk(ref_clk),
      .rst(rst),
      .extPin(eventPin[g]),
      .tk(tk)
    );

    // Overflow and next count
    always_comb
    begin
      overflow[g] = run[g] && tick[g] && (count[g] == TPB_COUNT_LAST);
      if (countWr[g])
        next_count[g] = wrData[g];
      else if (overflow[g] && pulseEn[g])
        next_count[g] = TPB_COUNT_WRAP;
      else if (overflow[g] && autoload[g])
        next_count[g] = refVal[g];
      else if (overflow[g])
        next_count[g] = TPB_COUNT_WRAP;
      else if (run[g] && tick[g])
        next_count[g] = count[g] + 8'h01;
      else
        next_count[g] = count[g];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
        count[g] <= TPB_COUNT_RESET;
      else
        count[g] <= next_count[g];
    end

    // Write-only reference
    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
        refVal[g] <= TPB_REF_RESET;
      else if (refWr[g])
        refVal[g] <= wrData[g];
    end

    // Request flag, set wins over clear
    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
        irqFlag[g] <= 1'b0;
      else if (overflow[g])
        irqFlag[g] <= 1'b1;
      else if (irqClr[g])
        irqFlag[g] <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
        irqReq[g] <= 1'b0;
      else
        irqReq[g] <= irqEn[g] && (irqFlag[g] || overflow[g]);
    end

    // Pulse-width compare on the next count, so the pin lines up with it
    always_comb
    begin
      if (!run[g] || !pulseEn[g])
        pulseOut[g] = 1'b0;
      else if (refWr[g])
        pulseOut[g] = next_count[g] < wrData[g];
      else
        pulseOut[g] = next_count[g] < refVal[g];
    end
  end

  // ==========================================================================
  // Tone divider on second timer
  always_comb
  begin
    if (!run[TPB_TIMER_B] || !toneOutputEnable)
      next_tone = 1'b0;
    else if (overflow[TPB_TIMER_B])
      next_tone = !tone;
    else
      next_tone = tone;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      tone <= 1'b0;
    else
      tone <= next_tone;
  end

  // ==========================================================================
  // Pin A drive
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      timerAPinOut <= 1'b0;
      timerAPinOe <= 1'b0;
    end
    else
    begin
      timerAPinOut <= pulseOut[TPB_TIMER_A];
      timerAPinOe <= pulseEn[TPB_TIMER_A];
    end
  end

  // ==========================================================================
  // Pin B drive: tone takes precedence
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      toneOutPinSignal <= 1'b0;
      timerBPinOe <= 1'b0;
    end
    else
    begin
      case ({toneOutputEnable, pulseEn[TPB_TIMER_B]})
        2'b10, 2'b11:
          toneOutPinSignal <= next_tone;
        2'b01:
          toneOutPinSignal <= pulseOut[TPB_TIMER_B];
        default:
          toneOutPinSignal <= 1'b0;
      endcase
      timerBPinOe <= toneOutputEnable || pulseEn[TPB_TIMER_B];
    end
  end

endmodule : tpb_timer_pwm

// *** tpb_pkg.sv ***
// Constants shared by the two-timer pulse-width and tone output block.
// Assumes a single reference clock and an active-high asynchronous reset.
package tpb_pkg;

  // ==========================================================================
  // Counter and reference values
  localparam logic [7:0] TPB_COUNT_RESET = 8'h00;
  localparam logic [7:0] TPB_REF_RESET = 8'h00;
  localparam logic [7:0] TPB_COUNT_WRAP = 8'h00;
  localparam logic [7:0] TPB_COUNT_LAST = 8'hff;

  // ==========================================================================
  // Rate field layout inside a mode register
  localparam int TPB_RATE_LSB = 4;
  localparam int TPB_RATE_MSB = 6;
  localparam logic [2:0] TPB_RATE_RESET = 3'h0;

  // ==========================================================================
  // Prescaler exponents: code 000 gives the slowest tick
  localparam logic [3:0] TPB_CPU_SHIFT_TOP = 4'h8;
  localparam logic [3:0] TPB_OSC_SHIFT_TOP = 4'h7;

  // ==========================================================================
  // Pin input synchroniser depth
  localparam int TPB_SYNC_STAGES = 3;

  // ==========================================================================
  // Timer indices
  localparam int TPB_TIMER_A = 0;
  localparam int TPB_TIMER_B = 1;
  localparam int TPB_NUM_TIMERS = 2;

endpackage : tpb_pkg

// *** tpb_tick_if.sv ***
// Carrier between a timer core and its rate divider.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ps
interface tpb_tick_if;
  logic run;
  logic [2:0] rate;
  logic oscSel;
  logic extMode;
  logic cpuTick;
  logic tick;

  modport ctrl (output run, output rate, output oscSel, output extMode, output cpuTick,
    input tick);
  modport div (input run, input rate, input oscSel, input extMode, input cpuTick,
    output tick);
endinterface : tpb_tick_if

// *** tpb_rate_div.sv ***
// Rate divider: turns the selected CPU, oscillator or external clock into count ticks.
// Assumes cpuTick is a one-cycle pulse at the CPU clock rate and extPin is asynchronous.
`timescale 1ns/1ps
module tpb_rate_div
  import tpb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // External event pin
  input wire logic extPin,
  // Tick carrier
  tpb_tick_if.div tk
);

  logic [TPB_SYNC_STAGES-1:0] extSync;
  logic extLevel;
  logic extStable;
  logic extRise;
  logic [7:0] preCnt;
  logic baseTick;
  logic rateHit;
  logic [3:0] shiftCpu;
  logic [3:0] shiftOsc;

  // ==========================================================================
  // Mask test on the prescaler
  function automatic logic prescaleHit(input logic [7:0] cnt, input logic [3:0] shift);
    logic [8:0] wide;
    logic [7:0] mask;
    wide = (9'h001 << shift) - 9'h001;
    mask = wide[7:0];
    return (cnt & mask) == mask;
  endfunction : prescaleHit

  // ==========================================================================
  // Source and rate selection
  always_comb
  begin
    shiftCpu = TPB_CPU_SHIFT_TOP - {1'b0, tk.rate};
    shiftOsc = TPB_OSC_SHIFT_TOP - {1'b0, tk.rate};
    baseTick = tk.oscSel ? 1'b1 : tk.cpuTick;
    rateHit = tk.oscSel ? prescaleHit(preCnt, shiftOsc) : prescaleHit(preCnt, shiftCpu);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      preCnt <= 8'h00;
    else if (!tk.run)
      preCnt <= 8'h00;
    else if (baseTick)
      preCnt <= preCnt + 8'h01;
  end

  // ==========================================================================
  // External event synchroniser
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      extSync <= '0;
    else
      extSync <= {extSync[TPB_SYNC_STAGES-2:0], extPin};
  end

  assign extStable = extSync[1] == extSync[2];
  assign extRise = extStable && extSync[2] && !extLevel;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      extLevel <= 1'b0;
    else if (extStable)
      extLevel <= extSync[2];
  end

  // ==========================================================================
  // Tick output
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      tk.tick <= 1'b0;
    else if (tk.extMode)
      tk.tick <= tk.run && extRise;
    else
      tk.tick <= tk.run && baseTick && rateHit;
  end

endmodule : tpb_rate_div

// *** tpb_timer_pwm_sva.sv ***
// Checker for the two-timer pulse and tone block, top ports only.
// Assumes one clock ref_clk and an asynchronous active-high rst.
`timescale 1ns/1ps
module tpb_timer_pwm_sva
  import tpb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Timer A
  input wire logic timerARun,
  input wire logic timerACountWr,
  input wire logic [7:0] timerAWrData,
  input wire logic [7:0] timerACount,
  input wire logic timerAPinOut,
  // Timer B
  input wire logic timerBRun,
  input wire logic timerBCountWr,
  input wire logic timerBIrqEnable,
  input wire logic timerBPulseOutEnable,
  input wire logic toneOutputEnable,
  input wire logic timerBIrqClr,
  input wire logic [7:0] timerBCount,
  input wire logic timerBIrqFlag,
  input wire logic timerBIrqReq,
  input wire logic toneOutPinSignal,
  input wire logic timerBPinOe
);
  // ==========================================================================
  // Defaults
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ==========================================================================
  // Properties
  stop_pin_a: assert property (!timerARun |=> !timerAPinOut)
    else $error("pin A high while stopped");
  stop_hold_a: assert property (!timerARun && !timerACountWr |=> $stable(timerACount))
    else $error("count moved while stopped");
  count_load_a: assert property (timerACountWr |=> timerACount == $past(timerAWrData))
    else $error("count write not taken");
  pin_b_oe_a: assert property (1'b1 |=>
    timerBPinOe == ($past(toneOutputEnable) | $past(timerBPulseOutEnable)))
    else $error("pin B enable wrong");
  wrap_flag_a: assert property ((timerBRun && timerBCount == 8'hff && !timerBCountWr)
    ##1 (timerBCount != 8'hff) |-> timerBIrqFlag)
    else $error("overflow left flag clear");
  tone_flip_a: assert property ((timerBRun && toneOutputEnable && timerBCount == 8'hff
    && !timerBCountWr) ##1 (timerBCount != 8'hff) |-> toneOutPinSignal != $past(toneOutPinSignal))
    else $error("tone did not toggle");
  flag_clear_a: assert property (timerBIrqClr && timerBCount != 8'hff |=> !timerBIrqFlag)
    else $error("flag not cleared");
  req_gate_a: assert property (timerBIrqReq |-> $past(timerBIrqEnable))
    else $error("request without enable");
endmodule : tpb_timer_pwm_sva

bind tpb_timer_pwm tpb_timer_pwm_sva chk_u (
  .ref_clk(ref_clk), .rst(rst),
  .timerARun(timerARun), .timerACountWr(timerACountWr), .timerAWrData(timerAWrData),
  .timerACount(timerACount), .timerAPinOut(timerAPinOut),
  .timerBRun(timerBRun), .timerBCountWr(timerBCountWr), .timerBIrqEnable(timerBIrqEnable),
  .timerBPulseOutEnable(timerBPulseOutEnable), .toneOutputEnable(toneOutputEnable),
  .timerBIrqClr(timerBIrqClr), .timerBCount(timerBCount), .timerBIrqFlag(timerBIrqFlag),
  .timerBIrqReq(timerBIrqReq), .toneOutPinSignal(toneOutPinSignal), .timerBPinOe(timerBPinOe)
);

// *** tb.sv ***
// Self-checking bench for the two-timer pulse and tone block.
// Assumes the checker binds itself; one clock, asynchronous reset.
`timescale 1ns/1ps
module tb
  import tpb_pkg::*;
;
  localparam int CDIV = 2;
  logic ref_clk, rst, timerARun, timerAOscSourceSel, timerAAutoload, timerAExtMode;
  logic timerAPulseOutEnable, timerAIrqEnable, timerACountWr, timerARefWr, timerAIrqClr;
  logic timerBRun, timerBOscSourceSel, timerBAutoload, timerBExtMode, timerBPulseOutEnable;
  logic timerBIrqEnable, toneOutputEnable, timerBCountWr, timerBRefWr, timerBIrqClr;
  logic timerAEventPin, timerBEventPin, timerAIrqFlag, timerBIrqFlag, timerAIrqReq;
  logic timerBIrqReq, timerAPinOut, timerAPinOe, toneOutPinSignal, timerBPinOe, tn;
  logic [2:0] timerARateField, timerBRateField;
  logic [7:0] timerAWrData, timerBWrData, timerACount, timerBCount, r, c;
  logic [31:0] seed;
  int mismatches, checks, i, n, hi;

  tpb_timer_pwm #(.CPU_DIV(CDIV)) dut_u (
    .ref_clk(ref_clk), .rst(rst),
    .timerARun(timerARun), .timerARateField(timerARateField),
    .timerAOscSourceSel(timerAOscSourceSel), .timerAAutoload(timerAAutoload),
    .timerAExtMode(timerAExtMode), .timerAPulseOutEnable(timerAPulseOutEnable),
    .timerAIrqEnable(timerAIrqEnable), .timerACountWr(timerACountWr),
    .timerARefWr(timerARefWr), .timerAWrData(timerAWrData), .timerAIrqClr(timerAIrqClr),
    .timerBRun(timerBRun), .timerBRateField(timerBRateField),
    .timerBOscSourceSel(timerBOscSourceSel), .timerBAutoload(timerBAutoload),
    .timerBExtMode(timerBExtMode), .timerBPulseOutEnable(timerBPulseOutEnable),
    .timerBIrqEnable(timerBIrqEnable), .toneOutputEnable(toneOutputEnable),
    .timerBCountWr(timerBCountWr), .timerBRefWr(timerBRefWr),
    .timerBWrData(timerBWrData), .timerBIrqClr(timerBIrqClr),
    .timerAEventPin(timerAEventPin), .timerBEventPin(timerBEventPin),
    .timerACount(timerACount), .timerBCount(timerBCount),
    .timerAIrqFlag(timerAIrqFlag), .timerBIrqFlag(timerBIrqFlag),
    .timerAIrqReq(timerAIrqReq), .timerBIrqReq(timerBIrqReq),
    .timerAPinOut(timerAPinOut), .timerAPinOe(timerAPinOe),
    .toneOutPinSignal(toneOutPinSignal), .timerBPinOe(timerBPinOe)
  );

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wait_change(output int k);
    logic [7:0] c0;
    c0 = timerACount;
    k = 0;
    while (timerACount === c0 && k < 3000)
    begin
      step(1);
      k++;
    end
  endtask : wait_change

  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // Clock and watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial
  begin
    #200000;
    mismatches++;
    tally_and_finish();
  end

  // ==========================================================================
  // Tests
  initial
  begin
    {timerARun, timerAOscSourceSel, timerAAutoload, timerAExtMode, timerAPulseOutEnable} = '0;
    {timerAIrqEnable, timerACountWr, timerARefWr, timerAIrqClr, timerAEventPin} = '0;
    {timerBRun, timerBOscSourceSel, timerBAutoload, timerBExtMode, timerBPulseOutEnable} = '0;
    {timerBIrqEnable, toneOutputEnable, timerBCountWr, timerBRefWr, timerBIrqClr} = '0;
    {timerBEventPin, timerARateField, timerBRateField, timerAWrData, timerBWrData} = '0;
    mismatches = 0;
    checks = 0;
    seed = 32'he1b9;
    rst = 1'b1;
    step(5);
    rst = 1'b0;
    cmp({timerACount, timerBCount}, {2{TPB_COUNT_RESET}});
    cmp({timerAPinOut, toneOutPinSignal, timerAIrqFlag, timerBIrqFlag}, 4'h0);
    // Pulse mode on A
    seed = xs(seed);
    r = seed[7:0];
    timerAWrData = r;
    timerARefWr = 1'b1;
    step(1);
    timerARefWr = 1'b0;
    timerAWrData = 8'h80;
    {timerAOscSourceSel, timerARateField, timerAAutoload} = 5'h1f;
    {timerAPulseOutEnable, timerAIrqEnable, timerARun} = 3'h7;
    step(3);
    hi = 0;
    for (i = 0; i < 520; i++)
    begin
      c = timerACount;
      timerACountWr = (i == 300);
      step(1);
      hi += (i < 256 && timerAPinOut === 1'b1);
      cmp(timerACount, (i == 300) ? 8'h80 : 8'(c + 8'h1));
      cmp(timerAPinOut, timerACount < r);
    end
    cmp(hi, r);
    cmp({timerAPinOe, timerAIrqFlag, timerAIrqReq}, 3'h7);
    timerARun = 1'b0;
    step(2);
    c = timerACount;
    step(4);
    cmp({timerACount, timerAPinOut}, {c, 1'b0});
    timerAIrqClr = 1'b1;
    step(1);
    timerAIrqClr = 1'b0;
    step(1);
    cmp(timerAIrqFlag, 1'b0);
    // Every rate code from both sources
    {timerAPulseOutEnable, timerAAutoload} = 2'h0;
    for (i = 0; i < 16; i++)
    begin
      {timerAOscSourceSel, timerARateField} = i[3:0];
      timerARun = 1'b1;
      wait_change(n);
      wait_change(n);
      cmp(n, i[3] ? (1 << (7 - i[2:0])) : (CDIV << (8 - i[2:0])));
      timerARun = 1'b0;
      step(2);
    end
    // External events ignore the source select
    {timerAExtMode, timerAOscSourceSel, timerARateField} = 5'h1f;
    timerARun = 1'b1;
    step(8);
    c = timerACount;
    for (i = 0; i < 3; i++)
    begin
      timerAEventPin = 1'b1;
      step(6);
      timerAEventPin = 1'b0;
      step(6);
    end
    cmp(timerACount, 8'(c + 8'h3));
    timerARun = 1'b0;
    // Tone on B with reload
    seed = xs(seed);
    r = {1'b1, seed[6:0]};
    timerBWrData = r;
    timerBRefWr = 1'b1;
    step(1);
    timerBRefWr = 1'b0;
    timerBWrData = 8'hf0;
    timerBCountWr = 1'b1;
    step(1);
    timerBCountWr = 1'b0;
    {timerBOscSourceSel, timerBRateField, timerBAutoload} = 5'h1f;
    {toneOutputEnable, timerBIrqEnable, timerBRun} = 3'h7;
    step(3);
    tn = 1'b0;
    for (i = 0; i < 400; i++)
    begin
      c = timerBCount;
      step(1);
      tn ^= (c == 8'hff);
      cmp(timerBCount, (c == 8'hff) ? r : 8'(c + 8'h1));
      cmp({toneOutPinSignal, timerBPinOe}, {tn, 1'b1});
    end
    cmp({timerBIrqFlag, timerBIrqReq}, 2'h3);
    timerBIrqEnable = 1'b0;
    step(2);
    cmp({timerBIrqFlag, timerBIrqReq}, 2'h2);
    timerBRun = 1'b0;
    step(2);
    timerBIrqClr = 1'b1;
    step(1);
    timerBIrqClr = 1'b0;
    step(1);
    cmp({timerBIrqFlag, toneOutPinSignal}, 2'h0);
    // Pulse mode on B, tone off
    seed = xs(seed);
    r = seed[15:8];
    timerBWrData = r;
    timerBRefWr = 1'b1;
    step(1);
    timerBRefWr = 1'b0;
    {toneOutputEnable, timerBPulseOutEnable, timerBRun} = 3'h3;
    step(3);
    for (i = 0; i < 300; i++)
    begin
      c = timerBCount;
      step(1);
      cmp(timerBCount, (c == 8'hff) ? TPB_COUNT_WRAP : 8'(c + 8'h1));
      cmp({toneOutPinSignal, timerBPinOe}, {timerBCount < r, 1'b1});
    end
    tally_and_finish();
  end
endmodule : tb
